// File: rtl/adcp_defs.svh
`ifndef ADCP_DEFS_SVH
`define ADCP_DEFS_SVH
`define ADCP_CLK_HZ 10000000
`define ADCP_CLK_PERIOD_NS 100
`define ADCP_BAUD_300 300
`define ADCP_BAUD_600 600
`define ADCP_BAUD_1200 1200
`define ADCP_BAUD_2400 2400
`define ADCP_BAUD_4800 4800
`define ADCP_BAUD_9600 9600
`define ADCP_BAUD_19200 19200
`define ADCP_BAUD_38400 38400
`define ADCP_BAUD_CODE_MIN 8'h01
`define ADCP_BAUD_CODE_MAX 8'h08
`define ADCP_BAUD_CODE_9600 8'h06
`define ADCP_FACTORY_ADDR 8'h01
`define ADCP_STRAP_ADDR 8'h00
`define ADCP_FACTORY_FMT 8'h00
`define ADCP_FMT_CKSUM_BIT 6
`define ADCP_FMT_KEEP_MASK 8'h43
`define ADCP_FMT_FREE_MASK 8'h03
`define ADCP_CHAR_CR 8'h0d
`define ADCP_CHAR_GT 8'h3e
`define ADCP_CHAR_QMARK 8'h3f
`define ADCP_CHAR_HASH 8'h23
`define ADCP_CHAR_DOLLAR 8'h24
`define ADCP_CHAR_PERCENT 8'h25
`define ADCP_CHAR_AT 8'h40
`define ADCP_CHAR_STAR 8'h2a
`define ADCP_CHAR_ZERO 8'h30
`define ADCP_CHAR_NINE 8'h39
`define ADCP_CHAR_A 8'h41
`define ADCP_CHAR_F 8'h46
`define ADCP_HEX_TEN 8'h0a
`define ADCP_REG_CFG 4'h0
`define ADCP_REG_STATUS 4'h4
`define ADCP_CFG_ADDR_LSB 0
`define ADCP_CFG_BAUD_LSB 8
`define ADCP_CFG_FMT_LSB 16
`define ADCP_CFG_MODBUS_BIT 24
`define ADCP_AXI_OKAY 2'h0
`define ADCP_AXI_SLVERR 2'h2
`define ADCP_BUF_LEN 3'h6
`define ADCP_NUM_CH 8
`define ADCP_CHAR_PER 7
`endif

// File: rtl/adcp_pkg.sv
package adcp_pkg;
	typedef struct packed {
		logic modbus;
		logic [7:0] fmt;
		logic [7:0] baud;
		logic [7:0] addr;
	} adcp_cfg_type;
	typedef enum logic [1:0] {
		RX_IDLE = 2'b00,
		RX_START = 2'b01,
		RX_DATA = 2'b10,
		RX_STOP = 2'b11
	} adcp_rx_type;
	typedef enum logic [1:0] {
		K_ALL = 2'b00,
		K_ONE = 2'b01,
		K_ERR = 2'b10
	} adcp_kind_type;
	typedef enum logic [2:0] {
		T_IDLE = 3'b000,
		T_LEAD = 3'b001,
		T_BODY = 3'b010,
		T_CK_HI = 3'b011,
		T_CK_LO = 3'b100,
		T_CR = 3'b101
	} adcp_tx_type;
endpackage

// File: rtl/adcp_top.sv
// Notes on behaviour
// - Characters use one start bit, eight data bits, one stop bit, no parity.
// - Line rates 300 to 38400 bps are selectable.
// - Factory settings: address 01, 9600 bps, checksum off.
// - Strap low at power-up forces address 00, 9600 bps, checksum off.
// - Rate, checksum and protocol changes only accepted in default mode.
// - Settings are kept in non-volatile storage and restored at power-up.
// - ASCII command set only; outside default mode the Modbus configuration bit just disables the ASCII parser.
// - A command starts with one leading code, then two hex address chars.
// - Commands and replies end with carriage return 0x0D.
// - Only commands for our own address, or the broadcast, are acted on.
// - Checksum is the eight-bit sum of preceding chars, as two hex chars.
// - With checksums on, commands are verified and replies carry one.
// - Replies start with '>' when accepted, '?' when rejected.
// - '#AA' returns '>' then all channel readings then carriage return.
// - Readings follow one of four formats selected by the format field.
// - A valid frame with a bad operation gets '?', address, return.
// - Syntax, link or address errors get no reply at all.
// - '#AAN' returns only channel N's reading.
// - Rate codes 01 to 08 map in order to 300 through 38400 baud.
// - Format bit 6 enables checksums, bits 1 to 0 pick the data format.
`timescale 1ns/1ps
`default_nettype none
`include "adcp_defs.svh"
module adcp_top import adcp_pkg::*; #(
	parameter int CLK_HZ = `ADCP_CLK_HZ,
	parameter int NUM_CH = `ADCP_NUM_CH,
	parameter int CHAR_PER = `ADCP_CHAR_PER,
	parameter int ADDR_W = 4
) (
	input wire logic aclk, // System clock.
	input wire logic aresetn, // Synchronous reset, active low.
	input wire logic config_strap_n, // Default-mode strap, low selects it.
	input wire logic nv_valid, // Stored settings are present.
	input wire adcp_cfg_type nv_cfg, // Stored settings image.
	output var adcp_cfg_type nv_wr_cfg, // Settings to store.
	output logic nv_wr, // Store request pulse.
	input wire logic rxd, // Serial receive line.
	output logic txd, // Serial transmit line.
	input wire logic [NUM_CH-1:0][CHAR_PER-1:0][7:0] ch_text, // Readings.
	output logic [1:0] data_fmt, // Reading format for the front end.
	output logic sync_pulse, // Broadcast synchronous sample pulse.
	output logic default_mode, // Running in strap-selected mode.
	input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address.
	input wire logic s_axi_awvalid, // Write address valid.
	output logic s_axi_awready, // Write address ready.
	input wire logic [31:0] s_axi_wdata, // Write data.
	input wire logic [3:0] s_axi_wstrb, // Write strobes.
	input wire logic s_axi_wvalid, // Write data valid.
	output logic s_axi_wready, // Write data ready.
	output logic [1:0] s_axi_bresp, // Write response.
	output logic s_axi_bvalid, // Write response valid.
	input wire logic s_axi_bready, // Write response ready.
	input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address.
	input wire logic s_axi_arvalid, // Read address valid.
	output logic s_axi_arready, // Read address ready.
	output logic [31:0] s_axi_rdata, // Read data.
	output logic [1:0] s_axi_rresp, // Read response.
	output logic s_axi_rvalid, // Read data valid.
	input wire logic s_axi_rready // Read data ready.
);
	localparam int CNT_W = 24;
	localparam int CH_W = $clog2(NUM_CH);
	localparam int POS_W = $clog2(CHAR_PER);
	localparam logic [CNT_W-1:0] CYC_TAB [8] = '{
		CNT_W'(CLK_HZ / `ADCP_BAUD_300), CNT_W'(CLK_HZ / `ADCP_BAUD_600),
		CNT_W'(CLK_HZ / `ADCP_BAUD_1200), CNT_W'(CLK_HZ / `ADCP_BAUD_2400),
		CNT_W'(CLK_HZ / `ADCP_BAUD_4800), CNT_W'(CLK_HZ / `ADCP_BAUD_9600),
		CNT_W'(CLK_HZ / `ADCP_BAUD_19200), CNT_W'(CLK_HZ / `ADCP_BAUD_38400)};

	function automatic logic [4:0] hex_val(input logic [7:0] c);
		hex_val = 5'h00;
		if (c >= `ADCP_CHAR_ZERO && c <= `ADCP_CHAR_NINE) begin
			hex_val = {1'b1, c[3:0]};
		end else if (c >= `ADCP_CHAR_A && c <= `ADCP_CHAR_F) begin
			hex_val = {1'b1, c[3:0] + 4'h9};
		end
	endfunction

	function automatic logic [7:0] hex_char(input logic [3:0] n);
		if (n <= 4'h9) begin
			hex_char = {4'h0, n} + `ADCP_CHAR_ZERO;
		end else begin
			hex_char = {4'h0, n} + `ADCP_CHAR_A - `ADCP_HEX_TEN;
		end
	endfunction

	function automatic logic baud_ok(input logic [7:0] code);
		baud_ok = code >= `ADCP_BAUD_CODE_MIN && code <= `ADCP_BAUD_CODE_MAX;
	endfunction

	// Configuration and register bus state.
	logic init_q, init_d, default_q, default_d, nv_wr_q, nv_wr_d;
	adcp_cfg_type cfg_q, cfg_d;
	logic [7:0] eff_addr_q, eff_addr_d, eff_baud_q, eff_baud_d;
	logic eff_ck_q, eff_ck_d, modbus_q, modbus_d;
	logic [1:0] fmt_q, fmt_d;
	logic awready_q, awready_d, wready_q, wready_d, bvalid_q, bvalid_d;
	logic arready_q, arready_d, rvalid_q, rvalid_d;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	logic [ADDR_W-1:0] waddr_q, waddr_d;
	logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
	logic [3:0] wstrb_q, wstrb_d;
	// Receiver and parser state.
	adcp_rx_type rx_st_q, rx_st_d;
	logic [CNT_W-1:0] rx_cnt_q, rx_cnt_d, bit_cyc;
	logic [2:0] rx_bit_q, rx_bit_d, len_q, len_d, blen;
	logic [7:0] rx_sh_q, rx_sh_d, lead_q, lead_d, sum;
	logic [7:0] buf_q [8];
	logic [7:0] buf_d [8];
	logic body_q, body_d, sync_q, sync_d;
	logic rx_byte, rx_ferr, eval, short_cmd, ck_ok, addr_ok, is_sync, chan_ok;
	logic cmd_go;
	logic [4:0] a_hi, a_lo, c_hi, c_lo;
	logic [7:0] chan_val;
	adcp_kind_type cmd_kind;
	// Transmitter state.
	adcp_tx_type tph_q, tph_d;
	adcp_kind_type kind_q, kind_d;
	logic [CH_W-1:0] ch_q, ch_d, last_ch_q, last_ch_d;
	logic [POS_W-1:0] pos_q, pos_d;
	logic [7:0] tsum_q, tsum_d, last_char_q, last_char_d, tx_char;
	logic tx_busy_q, tx_busy_d, txd_q, txd_d, tx_load, tx_idle;
	logic [CNT_W-1:0] tx_cnt_q, tx_cnt_d;
	logic [3:0] tx_bits_q, tx_bits_d;
	logic [8:0] tx_sh_q, tx_sh_d;
	logic [NUM_CH-1:0][CHAR_PER-1:0][7:0] snap_q, snap_d;

	assign bit_cyc = CYC_TAB[3'(eff_baud_q - `ADCP_BAUD_CODE_MIN)];
	assign tx_idle = tph_q == T_IDLE && !tx_busy_q;

	always_comb begin
		init_d = 1'b1;
		default_d = default_q;
		cfg_d = cfg_q;
		nv_wr_d = 1'b0;
		awready_d = awready_q;
		wready_d = wready_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		arready_d = arready_q;
		rvalid_d = rvalid_q;
		rresp_d = rresp_q;
		rdata_d = rdata_q;
		waddr_d = waddr_q;
		wdata_d = wdata_q;
		wstrb_d = wstrb_q;
		if (!init_q) begin
			default_d = !config_strap_n;
			if (nv_valid) begin
				cfg_d = nv_cfg;
				cfg_d.fmt = nv_cfg.fmt & `ADCP_FMT_KEEP_MASK;
				if (!baud_ok(nv_cfg.baud)) begin
					cfg_d.baud = `ADCP_BAUD_CODE_9600;
				end
			end
		end
		if (awready_q && s_axi_awvalid) begin
			awready_d = 1'b0;
			waddr_d = s_axi_awaddr;
		end
		if (wready_q && s_axi_wvalid) begin
			wready_d = 1'b0;
			wdata_d = s_axi_wdata;
			wstrb_d = s_axi_wstrb;
		end
		if (!awready_q && !wready_q && !bvalid_q) begin
			bvalid_d = 1'b1;
			bresp_d = `ADCP_AXI_OKAY;
			if ({waddr_q[ADDR_W-1:2], 2'b00} == ADDR_W'(`ADCP_REG_CFG)) begin
				nv_wr_d = 1'b1;
				if (wstrb_q[0]) begin
					cfg_d.addr = wdata_q[`ADCP_CFG_ADDR_LSB +: 8];
				end
				if (wstrb_q[1] && default_q &&
				    baud_ok(wdata_q[`ADCP_CFG_BAUD_LSB +: 8])) begin
					cfg_d.baud = wdata_q[`ADCP_CFG_BAUD_LSB +: 8];
				end
				if (wstrb_q[2]) begin
					cfg_d.fmt = wdata_q[`ADCP_CFG_FMT_LSB +: 8] &
						`ADCP_FMT_FREE_MASK;
					cfg_d.fmt[`ADCP_FMT_CKSUM_BIT] = default_q ?
						wdata_q[`ADCP_CFG_FMT_LSB + `ADCP_FMT_CKSUM_BIT] :
						cfg_q.fmt[`ADCP_FMT_CKSUM_BIT];
				end
				if (wstrb_q[3] && default_q) begin
					cfg_d.modbus = wdata_q[`ADCP_CFG_MODBUS_BIT];
				end
			end else if ({waddr_q[ADDR_W-1:2], 2'b00} !=
			             ADDR_W'(`ADCP_REG_STATUS)) begin
				bresp_d = `ADCP_AXI_SLVERR;
			end
		end
		if (bvalid_q && s_axi_bready) begin
			bvalid_d = 1'b0;
			awready_d = 1'b1;
			wready_d = 1'b1;
		end
		if (arready_q && s_axi_arvalid) begin
			arready_d = 1'b0;
			rvalid_d = 1'b1;
			rresp_d = `ADCP_AXI_OKAY;
			rdata_d = 32'h0000_0000;
			if ({s_axi_araddr[ADDR_W-1:2], 2'b00} ==
			    ADDR_W'(`ADCP_REG_CFG)) begin
				rdata_d = {7'h00, cfg_q};
			end else if ({s_axi_araddr[ADDR_W-1:2], 2'b00} ==
			             ADDR_W'(`ADCP_REG_STATUS)) begin
				rdata_d = {11'h000, body_q, !tx_idle, modbus_q, default_q,
					eff_ck_q, eff_baud_q, eff_addr_q};
			end else begin
				rresp_d = `ADCP_AXI_SLVERR;
			end
		end
		if (rvalid_q && s_axi_rready) begin
			rvalid_d = 1'b0;
			arready_d = 1'b1;
		end
		eff_addr_d = default_q ? `ADCP_STRAP_ADDR : cfg_q.addr;
		eff_baud_d = default_q ? `ADCP_BAUD_CODE_9600 : cfg_q.baud;
		eff_ck_d = !default_q && cfg_q.fmt[`ADCP_FMT_CKSUM_BIT];
		modbus_d = !default_q && cfg_q.modbus;
		fmt_d = cfg_q.fmt[1:0];
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			init_q <= 1'b0;
			default_q <= 1'b0;
			cfg_q <= '{modbus: 1'b0, fmt: `ADCP_FACTORY_FMT,
				baud: `ADCP_BAUD_CODE_9600, addr: `ADCP_FACTORY_ADDR};
			nv_wr_q <= 1'b0;
			eff_addr_q <= `ADCP_FACTORY_ADDR;
			eff_baud_q <= `ADCP_BAUD_CODE_9600;
			eff_ck_q <= 1'b0;
			modbus_q <= 1'b0;
			fmt_q <= 2'h0;
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			bvalid_q <= 1'b0;
			bresp_q <= `ADCP_AXI_OKAY;
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rresp_q <= `ADCP_AXI_OKAY;
			rdata_q <= 32'h0000_0000;
			waddr_q <= '0;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
		end else begin
			init_q <= init_d;
			default_q <= default_d;
			cfg_q <= cfg_d;
			nv_wr_q <= nv_wr_d;
			eff_addr_q <= eff_addr_d;
			eff_baud_q <= eff_baud_d;
			eff_ck_q <= eff_ck_d;
			modbus_q <= modbus_d;
			fmt_q <= fmt_d;
			awready_q <= awready_d;
			wready_q <= wready_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			arready_q <= arready_d;
			rvalid_q <= rvalid_d;
			rresp_q <= rresp_d;
			rdata_q <= rdata_d;
			waddr_q <= waddr_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
		end
	end

	always_comb begin
		rx_st_d = rx_st_q;
		rx_cnt_d = rx_cnt_q - 1'b1;
		rx_bit_d = rx_bit_q;
		rx_sh_d = rx_sh_q;
		rx_byte = 1'b0;
		rx_ferr = 1'b0;
		unique case (rx_st_q)
			RX_IDLE: begin
				rx_cnt_d = {1'b0, bit_cyc[CNT_W-1:1]};
				if (!rxd) begin
					rx_st_d = RX_START;
				end
			end
			RX_START: begin
				if (rx_cnt_q == '0) begin
					rx_st_d = rxd ? RX_IDLE : RX_DATA;
					rx_cnt_d = bit_cyc - 1'b1;
					rx_bit_d = 3'h0;
				end
			end
			RX_DATA: begin
				if (rx_cnt_q == '0) begin
					rx_sh_d = {rxd, rx_sh_q[7:1]};
					rx_cnt_d = bit_cyc - 1'b1;
					rx_bit_d = rx_bit_q + 3'h1;
					if (rx_bit_q == 3'h7) begin
						rx_st_d = RX_STOP;
					end
				end
			end
			RX_STOP: begin
				if (rx_cnt_q == '0) begin
					rx_st_d = RX_IDLE;
					rx_byte = rxd;
					rx_ferr = !rxd;
				end
			end
		endcase
		body_d = body_q;
		lead_d = lead_q;
		len_d = len_q;
		buf_d = buf_q;
		eval = 1'b0;
		if (rx_ferr) begin
			body_d = 1'b0;
		end else if (rx_byte && !modbus_q) begin
			if (rx_sh_q == `ADCP_CHAR_HASH || rx_sh_q == `ADCP_CHAR_DOLLAR ||
			    rx_sh_q == `ADCP_CHAR_PERCENT || rx_sh_q == `ADCP_CHAR_AT) begin
				body_d = 1'b1;
				lead_d = rx_sh_q;
				len_d = 3'h0;
			end else if (body_q) begin
				if (rx_sh_q == `ADCP_CHAR_CR) begin
					body_d = 1'b0;
					eval = 1'b1;
				end else if (len_q == `ADCP_BUF_LEN) begin
					body_d = 1'b0;
				end else begin
					buf_d[len_q] = rx_sh_q;
					len_d = len_q + 3'h1;
				end
			end
		end
		short_cmd = eff_ck_q && len_q < 3'h2;
		blen = eff_ck_q ? len_q - 3'h2 : len_q;
		sum = lead_q;
		for (int i = 0; i < 8; i++) begin
			if (3'(i) < blen) begin
				sum = sum + buf_q[i];
			end
		end
		c_hi = hex_val(buf_q[blen]);
		c_lo = hex_val(buf_q[blen + 3'h1]);
		ck_ok = !short_cmd && (!eff_ck_q || (c_hi[4] && c_lo[4] &&
			{c_hi[3:0], c_lo[3:0]} == sum));
		a_hi = hex_val(buf_q[0]);
		a_lo = hex_val(buf_q[1]);
		is_sync = lead_q == `ADCP_CHAR_HASH && blen == 3'h2 &&
			buf_q[0] == `ADCP_CHAR_STAR && buf_q[1] == `ADCP_CHAR_STAR;
		addr_ok = blen >= 3'h2 && a_hi[4] && a_lo[4] &&
			{a_hi[3:0], a_lo[3:0]} == eff_addr_q;
		chan_val = buf_q[2] - `ADCP_CHAR_ZERO;
		chan_ok = buf_q[2] >= `ADCP_CHAR_ZERO && chan_val < 8'(NUM_CH);
		if (lead_q == `ADCP_CHAR_HASH && blen == 3'h2) begin
			cmd_kind = K_ALL;
		end else if (lead_q == `ADCP_CHAR_HASH && blen == 3'h3 && chan_ok) begin
			cmd_kind = K_ONE;
		end else begin
			cmd_kind = K_ERR;
		end
		cmd_go = eval && ck_ok && addr_ok && tx_idle;
		sync_d = eval && ck_ok && is_sync;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_st_q <= RX_IDLE;
			rx_cnt_q <= '0;
			rx_bit_q <= 3'h0;
			rx_sh_q <= 8'h00;
			body_q <= 1'b0;
			lead_q <= 8'h00;
			len_q <= 3'h0;
			buf_q <= '{default: 8'h00};
			sync_q <= 1'b0;
		end else begin
			rx_st_q <= rx_st_d;
			rx_cnt_q <= rx_cnt_d;
			rx_bit_q <= rx_bit_d;
			rx_sh_q <= rx_sh_d;
			body_q <= body_d;
			lead_q <= lead_d;
			len_q <= len_d;
			buf_q <= buf_d;
			sync_q <= sync_d;
		end
	end

	always_comb begin
		unique case (tph_q)
			T_LEAD: tx_char = kind_q == K_ERR ? `ADCP_CHAR_QMARK :
				`ADCP_CHAR_GT;
			T_BODY: begin
				if (kind_q == K_ERR) begin
					tx_char = hex_char(pos_q == '0 ? eff_addr_q[7:4] :
						eff_addr_q[3:0]);
				end else begin
					tx_char = snap_q[ch_q][pos_q];
				end
			end
			T_CK_HI: tx_char = hex_char(tsum_q[7:4]);
			T_CK_LO: tx_char = hex_char(tsum_q[3:0]);
			T_CR: tx_char = `ADCP_CHAR_CR;
			default: tx_char = 8'h00;
		endcase
		tph_d = tph_q;
		kind_d = kind_q;
		ch_d = ch_q;
		last_ch_d = last_ch_q;
		pos_d = pos_q;
		tsum_d = tsum_q;
		snap_d = snap_q;
		last_char_d = last_char_q;
		tx_busy_d = tx_busy_q;
		txd_d = txd_q;
		tx_cnt_d = tx_cnt_q - 1'b1;
		tx_bits_d = tx_bits_q;
		tx_sh_d = tx_sh_q;
		tx_load = tph_q != T_IDLE && !tx_busy_q;
		if (cmd_go) begin
			tph_d = T_LEAD;
			kind_d = cmd_kind;
			ch_d = cmd_kind == K_ONE ? CH_W'(chan_val) : '0;
			last_ch_d = cmd_kind == K_ONE ? CH_W'(chan_val) :
				CH_W'(NUM_CH - 1);
			snap_d = ch_text;
		end
		if (tx_load) begin
			tx_busy_d = 1'b1;
			txd_d = 1'b0;
			tx_sh_d = {1'b1, tx_char};
			tx_bits_d = 4'h9;
			tx_cnt_d = bit_cyc - 1'b1;
			last_char_d = tx_char;
			unique case (tph_q)
				T_LEAD: begin
					tsum_d = tx_char;
					tph_d = T_BODY;
					pos_d = '0;
				end
				T_BODY: begin
					tsum_d = tsum_q + tx_char;
					if (pos_q == (kind_q == K_ERR ? POS_W'(1) :
					    POS_W'(CHAR_PER - 1))) begin
						pos_d = '0;
						if (kind_q == K_ERR || ch_q == last_ch_q) begin
							tph_d = eff_ck_q ? T_CK_HI : T_CR;
						end else begin
							ch_d = ch_q + 1'b1;
						end
					end else begin
						pos_d = pos_q + 1'b1;
					end
				end
				T_CK_HI: tph_d = T_CK_LO;
				T_CK_LO: tph_d = T_CR;
				T_CR: tph_d = T_IDLE;
				default: tph_d = T_IDLE;
			endcase
		end else if (tx_busy_q && tx_cnt_q == '0) begin
			tx_cnt_d = bit_cyc - 1'b1;
			if (tx_bits_q != 4'h0) begin
				txd_d = tx_sh_q[0];
				tx_sh_d = {1'b1, tx_sh_q[8:1]};
				tx_bits_d = tx_bits_q - 4'h1;
			end else begin
				tx_busy_d = 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tph_q <= T_IDLE;
			kind_q <= K_ALL;
			ch_q <= '0;
			last_ch_q <= '0;
			pos_q <= '0;
			tsum_q <= 8'h00;
			snap_q <= '0;
			last_char_q <= 8'h00;
			tx_busy_q <= 1'b0;
			txd_q <= 1'b1;
			tx_cnt_q <= '0;
			tx_bits_q <= 4'h0;
			tx_sh_q <= 9'h1ff;
		end else begin
			tph_q <= tph_d;
			kind_q <= kind_d;
			ch_q <= ch_d;
			last_ch_q <= last_ch_d;
			pos_q <= pos_d;
			tsum_q <= tsum_d;
			snap_q <= snap_d;
			last_char_q <= last_char_d;
			tx_busy_q <= tx_busy_d;
			txd_q <= txd_d;
			tx_cnt_q <= tx_cnt_d;
			tx_bits_q <= tx_bits_d;
			tx_sh_q <= tx_sh_d;
		end
	end

	assign nv_wr_cfg = cfg_q;
	assign nv_wr = nv_wr_q;
	assign txd = txd_q;
	assign data_fmt = fmt_q;
	assign sync_pulse = sync_q;
	assign default_mode = default_q;
	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign s_axi_rvalid = rvalid_q;

	a_frame_edges: assert property (@(posedge aclk) disable iff (!aresetn)
		($rose(tx_busy_q) |-> !txd_q) and ($fell(tx_busy_q) |-> txd_q))
		else $error("serial frame start or stop bit wrong");
	a_baud_count: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(tx_busy_q) |-> tx_cnt_q == bit_cyc - 1'b1)
		else $error("bit period does not match rate code");
	a_factory_cfg: assert property (@(posedge aclk) disable iff (!aresetn)
		!init_q |-> cfg_q.addr == `ADCP_FACTORY_ADDR &&
		cfg_q.baud == `ADCP_BAUD_CODE_9600 && !cfg_q.fmt[6])
		else $error("factory settings wrong after reset");
	a_strap_mode: assert property (@(posedge aclk) disable iff (!aresetn)
		(init_q && default_q) |=> eff_addr_q == `ADCP_STRAP_ADDR &&
		eff_baud_q == `ADCP_BAUD_CODE_9600 && !eff_ck_q)
		else $error("strap mode settings not forced");
	a_cfg_lock: assert property (@(posedge aclk) disable iff (!aresetn)
		(init_q && !default_q) |=> $stable(cfg_q.baud) &&
		$stable(cfg_q.modbus) && $stable(cfg_q.fmt[6]))
		else $error("locked setting changed outside default mode");
	a_reply_end: assert property (@(posedge aclk) disable iff (!aresetn)
		($fell(tx_busy_q) && tph_q == T_IDLE) |-> last_char_q == `ADCP_CHAR_CR)
		else $error("reply did not end with carriage return");
	a_accept_lead: assert property (@(posedge aclk) disable iff (!aresetn)
		(cmd_go && cmd_kind != K_ERR) |=> tx_load && tx_char == `ADCP_CHAR_GT)
		else $error("accepted reply does not start with >");
	a_reject_lead: assert property (@(posedge aclk) disable iff (!aresetn)
		(cmd_go && cmd_kind == K_ERR) |=> tx_load &&
		tx_char == `ADCP_CHAR_QMARK ##1 tph_q == T_BODY)
		else $error("rejected reply does not start with ?");
	a_addr_silent: assert property (@(posedge aclk) disable iff (!aresetn)
		(eval && !addr_ok && tph_q == T_IDLE) |=> tph_q == T_IDLE [*2])
		else $error("reply sent to foreign address");
	a_sum_silent: assert property (@(posedge aclk) disable iff (!aresetn)
		(eval && eff_ck_q && !ck_ok && tph_q == T_IDLE) |=> tph_q == T_IDLE)
		else $error("reply sent despite bad checksum");
endmodule
`default_nettype wire

// File: test/adcp_host.sv
`timescale 1ns/1ps
`default_nettype none
module adcp_host #(
	parameter int BIT = 16
) (
	input wire logic aclk, // System clock.
	input wire logic txd, // Reply line from the device.
	output logic rxd // Command line to the device.
);
	logic [7:0] got[$];
	logic [7:0] sh;
	initial rxd = 1'b1;
	// Call right after a rising edge; returns on the edge ending the stop bit.
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rxd <= f[i];
			repeat (BIT) @(posedge aclk);
		end
	endtask
	// A bad stop bit is logged as ff so that the compare fails.
	always begin
		@(negedge txd);
		repeat (BIT / 2) @(posedge aclk);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT) @(posedge aclk);
			sh[i] = txd;
		end
		repeat (BIT) @(posedge aclk);
		got.push_back(txd === 1'b1 ? sh : 8'hff);
	end
endmodule
`default_nettype wire

// File: test/tb_adcp_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checked++; if ((e) !== (s)) begin fails++; \
$display("ERROR %s exp %0h got %0h", n, e, s); end end
module tb_adcp_top import adcp_pkg::*;;
	localparam int BIT = 16;
	logic aclk = 0, aresetn = 0, config_strap_n = 1, nv_valid = 0, rxd, txd;
	adcp_cfg_type nv_cfg = '0, nv_wr_cfg;
	logic nv_wr, sync_pulse, default_mode;
	logic [1:0] data_fmt, s_axi_bresp, s_axi_rresp, r;
	logic [7:0][6:0][7:0] ch_text;
	logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid;
	logic [7:0] ex[$];
	int fails = 0, checked = 0, cyc = 0, syncs = 0, nvw = 0;
	string cmd[10] = '{"#01", "#013", "#01X", "$012", "#02", "#0a", "Z%#013",
		"#019", "@01", "#**"};
	int knd[10] = '{1, 2, 3, 3, 0, 0, 2, 3, 3, 0};
	adcp_top #(.CLK_HZ(38400 * 4)) uut (.aclk, .aresetn, .config_strap_n,
		.nv_valid, .nv_cfg, .nv_wr_cfg, .nv_wr, .rxd, .txd, .ch_text,
		.data_fmt, .sync_pulse, .default_mode, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	adcp_host #(.BIT(BIT)) uh (.aclk, .txd, .rxd);
	always #50 aclk = ~aclk;
	initial for (int c = 0; c < 8; c++) for (int j = 0; j < 7; j++)
		ch_text[c][j] = 8'(8'h41 + 7 * c + j);
	function automatic logic [7:0] h(logic [3:0] n);
		return n < 10 ? 8'h30 + n : 8'h37 + n;
	endfunction
	task automatic conclude();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge aclk) begin
		cyc++;
		if (sync_pulse === 1'b1) syncs++;
		if (nv_wr === 1'b1) nvw++;
		if (cyc == 90000) begin
			fails++;
			conclude();
		end
	end
	task automatic rst();
		aresetn <= 0;
		repeat (16) @(posedge aclk);
		aresetn <= 1;
		repeat (4) @(posedge aclk);
	endtask
	// Kinds: 0 silent, 1 all channels, 2 channel 3, 3 refusal.
	task automatic run(string c, int k, logic [7:0] a, bit ck);
		logic [7:0] s;
		ex.delete();
		if (k == 3) ex = '{8'h3f, h(a[7:4]), h(a[3:0])};
		if (k == 1 || k == 2) ex.push_back(8'h3e);
		for (int n = 0; n < 8; n++) for (int j = 0; j < 7; j++)
			if (k == 1 || (k == 2 && n == 3)) ex.push_back(ch_text[n][j]);
		s = 0;
		uh.got.delete();
		for (int i = 0; i < c.len(); i++) begin
			s += c[i];
			uh.send(c[i]);
		end
		if (ck) uh.send(h(s[7:4]));
		if (ck) uh.send(h(s[3:0]));
		uh.send(8'h0d);
		s = 0;
		foreach (ex[i]) s += ex[i];
		if (ck && k != 0) ex = {ex, h(s[7:4]), h(s[3:0])};
		if (k != 0) ex.push_back(8'h0d);
		repeat (ex.size() * 10 * BIT + 400) @(posedge aclk);
		`CHK("reply length", ex.size(), uh.got.size())
		foreach (ex[i]) `CHK("reply byte", ex[i], uh.got[i])
	endtask
	task automatic axw(logic [3:0] a, logic [31:0] v);
		bit aw, w;
		aw = 0;
		w = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		while (!(aw && w)) begin
			@(posedge aclk);
			aw |= s_axi_awready;
			w |= s_axi_wready;
			s_axi_awvalid <= !aw;
			s_axi_wvalid <= !w;
		end
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 0;
		@(posedge aclk);
	endtask
	task automatic axr(logic [3:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 0;
		@(posedge aclk);
	endtask
	initial begin
		repeat (16) @(posedge aclk);
		`CHK("txd idle", 1'b1, txd)
		`CHK("stored cfg", 25'h0000601, nv_wr_cfg)
		aresetn <= 1;
		repeat (4) @(posedge aclk);
		`CHK("default mode", 1'b0, default_mode)
		foreach (cmd[i])
			run(cmd[i], knd[i], 8'h01, 0);
		`CHK("sync pulses", 1, syncs)
		axr(4'h0);
		`CHK("cfg read", 32'h00000601, d)
		axw(4'h0, 32'h00400702);
		`CHK("cfg bresp", 2'h0, r)
		axr(4'h0);
		`CHK("cfg locked", 32'h00000602, d)
		axr(4'h8);
		`CHK("unmapped resp", 2'h2, r)
		nv_cfg <= nv_wr_cfg;
		nv_valid <= 1;
		rst();
		run("#023", 2, 8'h02, 0);
		config_strap_n <= 0;
		rst();
		`CHK("default mode", 1'b1, default_mode)
		run("#003", 2, 8'h00, 0);
		axw(4'h0, 32'h00410602);
		`CHK("store pulses", 2, nvw)
		axr(4'h4);
		`CHK("strap cksum off", 1'b0, d[16])
		axr(4'h0);
		`CHK("cfg in default", 32'h00410602, d)
		nv_cfg <= nv_wr_cfg;
		config_strap_n <= 1;
		rst();
		axr(4'h4);
		`CHK("checksum on", 1'b1, d[16])
		`CHK("data format", 2'h1, data_fmt)
		run("#023", 2, 8'h02, 1);
		run("#02300", 0, 8'h02, 0);
		conclude();
	end
endmodule
`default_nettype wire
